// ===== design/rcd_regs.svh
// register offsets, field positions, reset values and timing counts
// of the reset phase clock divider; included by package and modules.
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH

// register byte offsets
`define RCD_OFS_CTRL          8'h00
`define RCD_OFS_DIV           8'h04
`define RCD_OFS_STATUS        8'h08

// control register fields
`define RCD_CTRL_EXTSRC_BIT   0
`define RCD_CTRL_PLLEN_BIT    1
`define RCD_CTRL_RESET        32'h0000_0000

// division register fields, four bits per ratio
`define RCD_DIV_CPU_LSB       0
`define RCD_DIV_PER_LSB       4
`define RCD_DIV_MEM_LSB       8
`define RCD_DIV_FIELD_W       4

// status register fields
`define RCD_ST_PHASE_LSB      0
`define RCD_ST_BOOT_LSB       3
`define RCD_ST_ORDER_BIT      5
`define RCD_ST_MODE_BIT       6
`define RCD_ST_BYPASS_BIT     7

// division ratios of the input clock
`define RCD_RATIO_RESET       4'h8
`define RCD_RATIO_CPU_DEF     4'h1
`define RCD_RATIO_PER_DEF     4'h2
`define RCD_RATIO_MEM_DEF     4'h2
`define RCD_RATIO_AUX         4'h8

// internal reset stretch, in input clock cycles
`define RCD_STRETCH_INPUT_CLOCK     10'h200
`define RCD_STRETCH_PLL       10'h200

`endif

// ===== design/rcd_pkg.sv
// types shared by the reset phase clock divider modules.
// assumes rcd_regs.svh sits on the include path.
`include "rcd_regs.svh"

package rcd_pkg;

  typedef enum logic [2:0] {
    RCD_PH_HOLD    = 3'b001,
    RCD_PH_STRETCH = 3'b010,
    RCD_PH_RUN     = 3'b100
  } rcd_phase_t;

  typedef struct packed {
    logic [3:0] mem;
    logic [3:0] per;
    logic [3:0] cpu;
  } rcd_ratio_t;

  typedef struct packed {
    logic       pll_enable;
    logic       ext_src_sel;
  } rcd_ctrl_t;

  typedef struct packed {
    logic       tick;
    logic       level;
  } rcd_clk_t;

  typedef struct packed {
    logic [1:0] boot_select;
    logic       byte_order_select;
  } rcd_strap_t;

endpackage

// ===== design/rcd_div.sv
// one counter based clock divider: a tick every ratio input clocks
// and a square level. assumes ratio comes from logic on clk.
`include "rcd_regs.svh"

module rcd_div #(
  parameter int W = `RCD_DIV_FIELD_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // requested ratio
  input  wire logic [W-1:0] ratio,
  // divided clock
  output rcd_pkg::rcd_clk_t clk_out
);

  logic [W-1:0] ratio_reg;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] ratio_act;
  logic         wrap;
  logic         tick_reg;
  logic         level_reg;

  // a zero ratio would stall the counter, treat it as one
  function automatic logic [W-1:0] safe_ratio(input logic [W-1:0] r);
    safe_ratio = (r == '0) ? W'(1) : r;
  endfunction

  // new ratio is taken only at a period boundary
  assign wrap      = (cnt_reg >= safe_ratio(ratio_reg) - W'(1));
  assign ratio_act = wrap ? safe_ratio(ratio) : safe_ratio(ratio_reg);
  assign cnt_next  = wrap ? '0 : cnt_reg + W'(1);

  always_ff @(posedge clk) begin
    // parked on the last count so the first edge out of reset starts a full period
    if (rst) begin
      ratio_reg <= W'(`RCD_RATIO_RESET);
      cnt_reg   <= W'(`RCD_RATIO_RESET) - W'(1);
    end else begin
      cnt_reg <= cnt_next;
      if (wrap) begin
        ratio_reg <= ratio;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      tick_reg  <= (cnt_next == '0);
      level_reg <= ({1'b0, cnt_next} < (({1'b0, ratio_act} + (W+1)'(1)) >> 1));
    end
  end

  assign clk_out.tick  = tick_reg;
  assign clk_out.level = level_reg;

endmodule

// ===== design/rcd_top.sv
// reset phase clock divider: tracks the reset pin through hold,
// stretch and run phases and sets every divided clock's ratio.
// assumes clk is the input clock and pins are asynchronous to it.
//
// The address map and the address-and-strobe port were decided locally.
`include "rcd_regs.svh"

// Operation
// - while the reset pin is asserted every clock runs at input divided by eight.
// - after pin release internal reset is stretched, clocks still divided by eight.
// - with pin and internal reset inactive all clocks go to default ratios.
// - after internal reset the processor clock runs undivided.
// - after internal reset the peripheral clock runs at input divided by two.
// - after internal reset the memory interface clock runs at input divided by two.
// - with source select zero the memory interface clock drives the external pin.
// - after internal reset the auxiliary output runs at input divided by eight.
// - with input clock mode one the stretch lasts exactly 512 input cycles.
// - boot and byte order selections are captured when the reset pin rises.
// - after reset the multiplier loop is bypassed until software reprograms it.
module rcd_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // board pins, asynchronous
  input  wire logic        reset_pin_n,
  input  wire logic        input_clock_mode_select,
  input  wire logic [1:0]  boot_select,
  input  wire logic        byte_order_select,
  input  wire logic        ext_mem_clock_in,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // divided clocks
  output rcd_pkg::rcd_clk_t cpu_clock,
  output rcd_pkg::rcd_clk_t peripheral_clock,
  output rcd_pkg::rcd_clk_t memory_if_clock,
  output logic             ext_mem_clock_out,
  output logic             aux_slow_clock_out,
  // reset and configuration outputs
  output logic             internal_reset,
  output logic             pll_bypass,
  output rcd_pkg::rcd_strap_t strap_out
);

  // pin synchronisers, first stage read only by second stage
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic       pin_rel_d_reg;
  logic       pin_released;
  logic       mode_sync;
  logic [1:0] boot_sync;
  logic       order_sync;
  logic       ext_in_sync;

  // a pin pulse shorter than one clock may slip past unseen
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {ext_mem_clock_in, byte_order_select, boot_select,
                     input_clock_mode_select, reset_pin_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign pin_released = pin_s2_reg[0];
  assign mode_sync    = pin_s2_reg[1];
  assign boot_sync    = pin_s2_reg[3:2];
  assign order_sync   = pin_s2_reg[4];
  assign ext_in_sync  = pin_s2_reg[5];

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_rel_d_reg <= 1'b0;
    end else begin
      pin_rel_d_reg <= pin_released;
    end
  end

  // straps are caught on the rising edge of the reset pin
  logic [1:0] boot_reg;
  logic       order_reg;
  logic       mode_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_reg  <= 2'h0;
      order_reg <= 1'b0;
      mode_reg  <= 1'b1;
    end else if (pin_released && !pin_rel_d_reg) begin
      boot_reg  <= boot_sync;
      order_reg <= order_sync;
      mode_reg  <= mode_sync;
    end
  end

  // reset phase sequencer
  // a pin drop in any phase goes straight back to hold
  rcd_pkg::rcd_phase_t phase_reg;
  rcd_pkg::rcd_phase_t phase_next;
  logic [9:0]          stretch_reg;
  logic                run_next;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      rcd_pkg::RCD_PH_HOLD: begin
        if (pin_released) begin
          phase_next = rcd_pkg::RCD_PH_STRETCH;
        end
      end
      rcd_pkg::RCD_PH_STRETCH: begin
        if (!pin_released) begin
          phase_next = rcd_pkg::RCD_PH_HOLD;
        end else if (stretch_reg == 10'h001) begin
          phase_next = rcd_pkg::RCD_PH_RUN;
        end
      end
      rcd_pkg::RCD_PH_RUN: begin
        if (!pin_released) begin
          phase_next = rcd_pkg::RCD_PH_HOLD;
        end
      end
      default: phase_next = rcd_pkg::RCD_PH_HOLD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= rcd_pkg::RCD_PH_HOLD;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // the stretch length is counted from the cycle after the release is seen
  // mode zero loads its own count, RCD_STRETCH_PLL, which has the same length
  always_ff @(posedge clk) begin
    if (rst) begin
      stretch_reg <= `RCD_STRETCH_INPUT_CLOCK;
    end else if (phase_reg != rcd_pkg::RCD_PH_STRETCH) begin
      stretch_reg <= mode_sync ? `RCD_STRETCH_INPUT_CLOCK : `RCD_STRETCH_PLL;
    end else if (stretch_reg != 10'h000) begin
      stretch_reg <= stretch_reg - 10'h001;
    end
  end

  assign run_next = (phase_next == rcd_pkg::RCD_PH_RUN);

  always_ff @(posedge clk) begin
    if (rst) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= !run_next;
    end
  end

  // software registers, reloaded with defaults while the device is held
  // writes before run are dropped, not queued, so set ratios after reset
  rcd_pkg::rcd_ctrl_t  ctrl_reg;
  rcd_pkg::rcd_ratio_t ratio_reg;
  logic                in_reset;

  assign in_reset = (phase_reg != rcd_pkg::RCD_PH_RUN);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      ctrl_reg <= rcd_pkg::rcd_ctrl_t'(2'(`RCD_CTRL_RESET));
    end else if (reg_wr && hit(reg_addr, `RCD_OFS_CTRL)) begin
      ctrl_reg.ext_src_sel <= reg_wdata[`RCD_CTRL_EXTSRC_BIT];
      ctrl_reg.pll_enable  <= reg_wdata[`RCD_CTRL_PLLEN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || in_reset) begin
      ratio_reg.cpu <= `RCD_RATIO_CPU_DEF;
      ratio_reg.per <= `RCD_RATIO_PER_DEF;
      ratio_reg.mem <= `RCD_RATIO_MEM_DEF;
    end else if (reg_wr && hit(reg_addr, `RCD_OFS_DIV)) begin
      ratio_reg.cpu <= reg_wdata[`RCD_DIV_CPU_LSB +: `RCD_DIV_FIELD_W];
      ratio_reg.per <= reg_wdata[`RCD_DIV_PER_LSB +: `RCD_DIV_FIELD_W];
      ratio_reg.mem <= reg_wdata[`RCD_DIV_MEM_LSB +: `RCD_DIV_FIELD_W];
    end
  end

  // loop stays bypassed from reset until software enables it
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_bypass <= 1'b1;
    end else begin
      pll_bypass <= in_reset || !ctrl_reg.pll_enable;
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`RCD_ST_PHASE_LSB +: 3] = phase_reg;
    status_word[`RCD_ST_BOOT_LSB +: 2]  = boot_reg;
    status_word[`RCD_ST_ORDER_BIT]      = order_reg;
    status_word[`RCD_ST_MODE_BIT]       = mode_reg;
    status_word[`RCD_ST_BYPASS_BIT]     = pll_bypass;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (1'b1)
        hit(reg_addr, `RCD_OFS_CTRL): reg_rdata <= {30'h0, ctrl_reg};
        hit(reg_addr, `RCD_OFS_DIV):  reg_rdata <= {20'h0, ratio_reg};
        hit(reg_addr, `RCD_OFS_STATUS): reg_rdata <= status_word;
        default:                      reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ratio selection: every domain runs at divide by eight until run
  // software ratios only apply in run; a pin drop forces eight again
  rcd_pkg::rcd_ratio_t ratio_sel;
  logic [3:0]          aux_ratio;

  always_comb begin
    if (in_reset) begin
      ratio_sel.cpu = `RCD_RATIO_RESET;
      ratio_sel.per = `RCD_RATIO_RESET;
      ratio_sel.mem = `RCD_RATIO_RESET;
    end else begin
      ratio_sel = ratio_reg;
    end
  end

  assign aux_ratio = in_reset ? `RCD_RATIO_RESET : `RCD_RATIO_AUX;

  // the divider swaps ratio only at its own wrap, so no runt pulses
  rcd_pkg::rcd_clk_t mem_clk;
  rcd_pkg::rcd_clk_t aux_clk;

  rcd_div #(.W(`RCD_DIV_FIELD_W)) u_cpu_div (
    .clk     (clk),
    .rst     (rst),
    .ratio   (ratio_sel.cpu),
    .clk_out (cpu_clock)
  );

  rcd_div #(.W(`RCD_DIV_FIELD_W)) u_per_div (
    .clk     (clk),
    .rst     (rst),
    .ratio   (ratio_sel.per),
    .clk_out (peripheral_clock)
  );

  rcd_div #(.W(`RCD_DIV_FIELD_W)) u_mem_div (
    .clk     (clk),
    .rst     (rst),
    .ratio   (ratio_sel.mem),
    .clk_out (mem_clk)
  );

  rcd_div #(.W(`RCD_DIV_FIELD_W)) u_aux_div (
    .clk     (clk),
    .rst     (rst),
    .ratio   (aux_ratio),
    .clk_out (aux_clk)
  );

  assign memory_if_clock = mem_clk;

  // pin outputs retimed once; costs one cycle of lag against the divider
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_mem_clock_out  <= 1'b0;
      aux_slow_clock_out <= 1'b0;
    end else begin
      ext_mem_clock_out  <= ctrl_reg.ext_src_sel ? ext_in_sync : mem_clk.level;
      aux_slow_clock_out <= aux_clk.level;
    end
  end

  // straps stay frozen through run; only the next pin rise reloads them
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_out <= 3'h0;
    end else begin
      strap_out.boot_select       <= boot_reg;
      strap_out.byte_order_select <= order_reg;
    end
  end

endmodule

// ===== verification/rcd_top_sva.sv
// assertions for the reset phase clock divider, bound to rcd_top.
// assumes one clock domain and rst synchronous, active high.
module rcd_top_sva (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // pins and register port
  input wire logic               reset_pin_n,
  input wire logic               ext_mem_clock_in,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  // outputs under watch
  input wire rcd_pkg::rcd_clk_t  cpu_clock,
  input wire rcd_pkg::rcd_clk_t  peripheral_clock,
  input wire rcd_pkg::rcd_clk_t  memory_if_clock,
  input wire logic               ext_mem_clock_out,
  input wire logic               aux_slow_clock_out,
  input wire logic               internal_reset,
  input wire logic               pll_bypass,
  input wire rcd_pkg::rcd_strap_t strap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ext_sel_reg, touched_reg;
  logic [9:0] run_cnt_reg, pin_cnt_reg;
  // 17 run cycles cover the slowest wrap before defaults apply
  wire        settled = run_cnt_reg > 10'h10;
  always_ff @(posedge clk) begin
    if (rst || internal_reset) begin
      ext_sel_reg <= 1'b0;
      touched_reg <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      ext_sel_reg <= reg_wdata[0];
    end else if (reg_wr && reg_addr == 8'h04) begin
      touched_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || internal_reset || touched_reg) run_cnt_reg <= 10'h0;
    else if (!run_cnt_reg[9]) run_cnt_reg <= run_cnt_reg + 10'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || !reset_pin_n) pin_cnt_reg <= 10'h0;
    else if (pin_cnt_reg != 10'h3ff) pin_cnt_reg <= pin_cnt_reg + 10'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence aux_wave;
    aux_slow_clock_out [*3] ##1 (!aux_slow_clock_out) [*4] ##1 aux_slow_clock_out;
  endsequence
  reset_div8_a: assert property (
    internal_reset [*3] ##0 cpu_clock.tick |=> (!cpu_clock.tick) [*7])
    else $error("cpu clock not div 8 in reset");
  cpu_full_a: assert property (settled |-> cpu_clock.tick && cpu_clock.level)
    else $error("cpu clock divided in run");
  per_half_a: assert property (
    settled && peripheral_clock.tick |=> !peripheral_clock.tick ##1 peripheral_clock.tick)
    else $error("peripheral clock not div 2");
  mem_half_a: assert property (
    settled |=> memory_if_clock.level != $past(memory_if_clock.level))
    else $error("memory clock not div 2");
  ext_follow_a: assert property (
    !ext_sel_reg && !internal_reset |=> ext_mem_clock_out == $past(memory_if_clock.level))
    else $error("ext clock not following memory clock");
  aux_eighth_a: assert property ($rose(aux_slow_clock_out) |=> aux_wave)
    else $error("aux clock not div 8");
  stretch_len_a: assert property (
    $fell(internal_reset) |-> pin_cnt_reg inside {[10'h200:10'h204]})
    else $error("stretch length wrong");
  strap_hold_a: assert property (!internal_reset |-> $stable(strap_out))
    else $error("straps changed in run");
  bypass_on_a: assert property (internal_reset [*4] |-> pll_bypass)
    else $error("loop not bypassed in reset");
  per_level_a: assert property (
    settled && peripheral_clock.tick |-> peripheral_clock.level ##1 !peripheral_clock.level)
    else $error("peripheral level not half duty");
  ext_alt_a: assert property (
    ext_sel_reg && !internal_reset |=> ext_mem_clock_out == $past(ext_mem_clock_in, 3))
    else $error("ext clock not following alternate source");
endmodule

// ===== verification/rcd_board.sv
// board model: reset pin, straps and a spare memory clock source.
// assumes the bench asks for reset and strap values on the req inputs.
module rcd_board (
  // clock and bench requests
  input  wire logic       clk,
  input  wire logic       pin_low_req,
  input  wire logic [3:0] strap_req,
  // board pins
  output logic            reset_pin_n,
  output logic            input_clock_mode_select,
  output logic [1:0]      boot_select,
  output logic            byte_order_select,
  output logic            ext_mem_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_cnt = 0;
  initial {reset_pin_n, input_clock_mode_select, boot_select, byte_order_select} = 5'h00;
  initial ext_mem_clock_in = 1'b0;
  always @(posedge clk) begin
    reset_pin_n <= !pin_low_req;
    input_clock_mode_select <= strap_req[3];
    hold_cnt <= pin_low_req ? 0 : hold_cnt + 1;
    // straps only hold 16 clocks past the pin rise, then go wrong on purpose
    {boot_select, byte_order_select} <= (pin_low_req || hold_cnt < 16) ?
      strap_req[2:0] : ~strap_req[2:0];
    ext_mem_clock_in <= (hold_cnt % 3) == 0;
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench: board model, design and bound checker.
// assumes design files, rcd_board.sv and rcd_top_sva.sv compile first.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, pin_low, reg_wr, reg_rd, aux_q;
  logic reset_pin_n, input_clock_mode_select, byte_order_select, ext_mem_clock_in;
  logic ext_mem_clock_out, aux_slow_clock_out, internal_reset, pll_bypass;
  logic [1:0] boot_select;
  logic [3:0] strap;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, m_ctrl, m_div;
  rcd_pkg::rcd_clk_t cpu_clock, peripheral_clock, memory_if_clock;
  rcd_pkg::rcd_strap_t strap_out;
  int errors = 0, num_checks = 0, seed = 27, n;
  wire [3:0] ticks = {aux_slow_clock_out && !aux_q, memory_if_clock.tick,
                      peripheral_clock.tick, cpu_clock.tick};
  rcd_board i_board (.clk(clk), .pin_low_req(pin_low), .strap_req(strap),
    .reset_pin_n(reset_pin_n), .input_clock_mode_select(input_clock_mode_select),
    .boot_select(boot_select), .byte_order_select(byte_order_select),
    .ext_mem_clock_in(ext_mem_clock_in));
  rcd_top i_dut (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .input_clock_mode_select(input_clock_mode_select), .boot_select(boot_select),
    .byte_order_select(byte_order_select), .ext_mem_clock_in(ext_mem_clock_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_clock(cpu_clock), .peripheral_clock(peripheral_clock),
    .memory_if_clock(memory_if_clock), .ext_mem_clock_out(ext_mem_clock_out),
    .aux_slow_clock_out(aux_slow_clock_out), .internal_reset(internal_reset),
    .pll_bypass(pll_bypass), .strap_out(strap_out));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) aux_q <= aux_slow_clock_out;
  function automatic int exp_period(int s);
    return s < 3 ? int'(m_div[4*s +: 4]) : 8;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // model takes writes only once the pin is released
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    if (!pin_low && a == 8'h00) m_ctrl = v & 32'h3;
    if (!pin_low && a == 8'h04) m_div = v & 32'hfff;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic period(input int s);
    int k;
    k = 0;
    n = 0;
    while (ticks[s] !== 1'b1 && k < 64) begin
      tick(1);
      k++;
    end
    do begin
      tick(1);
      n++;
    end while (ticks[s] !== 1'b1 && n < 64);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    pin_low = 1'b1;
    strap = 4'h8;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      pin_low <= 1'b1;
      strap <= 4'($random(seed));
      m_ctrl = 32'h0;
      m_div = 32'h221;
      tick(20);
      wr(8'h00, 32'h3);
      rd(8'h00);
      `CHK(d, m_ctrl)
      rd(8'h08);
      `CHK(d[2:0], 3'h1)
      period(0);
      `CHK(n, 8)
      pin_low <= 1'b0;
      n = 0;
      while (internal_reset !== 1'b0 && n < 2000) begin
        tick(1);
        n++;
      end
      `CHK(n > 513 && n < 519, 1'b1)
      `CHK(strap_out, strap[2:0])
      tick(20);
      `CHK(pll_bypass, 1'b1)
      rd(8'h08);
      `CHK(d[7:0], {1'b1, strap[3], strap[0], strap[2:1], 3'h4})
      rd(8'h0c);
      `CHK(d, 32'h0)
      for (int s = 0; s < 4; s++) begin
        period(s);
        `CHK(n, exp_period(s))
      end
      d = 32'h221 + ($unsigned($random(seed)) & 32'h7);
      wr(8'h04, d);
      tick(20);
      period(0);
      `CHK(n, exp_period(0))
      rd(8'h04);
      `CHK(d, m_div)
      wr(8'h00, 32'h3);
      tick(4);
      `CHK(pll_bypass, 1'b0)
      rd(8'h00);
      `CHK(d, m_ctrl)
      $display("reset round %0d done", i);
    end
    conclude;
  end
  // two rounds take about 1300 cycles; 25000 leaves wide margin
  initial begin
    #100000;
    errors++;
    conclude;
  end
endmodule
bind rcd_top rcd_top_sva i_sva (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
  .ext_mem_clock_in(ext_mem_clock_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cpu_clock(cpu_clock), .peripheral_clock(peripheral_clock),
  .memory_if_clock(memory_if_clock), .ext_mem_clock_out(ext_mem_clock_out),
  .aux_slow_clock_out(aux_slow_clock_out), .internal_reset(internal_reset),
  .pll_bypass(pll_bypass), .strap_out(strap_out));
